// >>> include/cache_lock_pkg.sv
// Constants for the cache lock and invalidate controller.
// Assumes the core moves 32-bit words to and from its configuration registers
// and that control bits are counted big-endian (big-endian bit k is bit 31-k here).
package cache_lock_pkg;

  // ----------------------------------------------------------------
  // Cache geometry
  // ----------------------------------------------------------------
  localparam int BLOCK_BYTES = 32;
  localparam int OFF_W = 5;
  localparam int NUM_SETS = 128;
  localparam int NUM_WAYS = 8;
  localparam int DATA_BLOCKS = 32'h400;
  localparam int ADDR_W = 32;
  localparam int BUS_DATA_W = 64;
  localparam int DWORD_ADDR_BIT = 2;

  // ----------------------------------------------------------------
  // Register selection and reset values
  // ----------------------------------------------------------------
  localparam logic SEL_CACHE_CTRL = 1'b0;
  localparam logic SEL_WAY_LOCK = 1'b1;
  localparam logic [31:0] CACHE_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WAY_LOCK_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions (little-endian index = 31 - big-endian bit)
  // ----------------------------------------------------------------
  localparam int WHOLE_WHOLE_INSTR_CACHE_LOCK_BIT = 13;
  localparam int IFLASH_INV_BIT = 11;
  localparam int DFLASH_INV_BIT = 10;
  localparam int IWAY_LOCK_LSB = 13;
  localparam int IWAY_LOCK_W = 3;
  localparam logic [31:0] WHOLE_WHOLE_INSTR_CACHE_LOCK_MASK = 32'h0000_2000;
  localparam logic [31:0] IFLASH_INV_MASK = 32'h0000_0800;
  localparam logic [31:0] DFLASH_INV_MASK = 32'h0000_0400;

endpackage : cache_lock_pkg

// >>> src/lock_victim_sel.sv
// Victim chooser for one indexed set of a set-associative cache.
// Assumes valid and lock vectors are already resolved for that set.
`timescale 1ns/1ps
module lock_victim_sel #(
  parameter int WAYS = 8,
  parameter int WAY_W = 3
) (
  input wire logic [WAYS-1:0] i_valid,
  input wire logic [WAYS-1:0] i_locked,
  input wire logic [WAY_W-1:0] i_rr_ptr,
  output logic [WAY_W-1:0] o_way,
  output logic o_found,
  output logic o_victim_valid
);

  logic [WAY_W-1:0] idx;

  // Invalid entries are taken first, even inside a locked way, so locked ways
  // can still be filled; a valid line is only displaced from an unlocked way.
  always_comb begin
    o_way = '0;
    o_found = 1'b0;
    o_victim_valid = 1'b0;
    idx = '0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (!i_valid[w]) begin
        o_way = WAY_W'(w);
        o_found = 1'b1;
      end
    end
    if (!o_found) begin
      for (int k = WAYS - 1; k >= 0; k--) begin
        idx = WAY_W'(int'(i_rr_ptr) + k);
        if (!i_locked[idx]) begin
          o_way = idx;
          o_found = 1'b1;
          o_victim_valid = 1'b1;
        end
      end
    end
  end

endmodule : lock_victim_sel

// >>> src/cache_lock_invalidate_ctrl.sv
// Lock, flash invalidate, fill and block flush control for split I and D caches.
// Assumes fetch and load/store units give at most one request each per cycle
// and that software pulses the flash invalidate bits by two register writes.
//
// Contract
// - Instruction flash-invalidate pulse clears all I blocks
// - Data flash-invalidate pulse clears D, no writeback
// - Block flush writes back dirty, then invalidates
// - Caches use 32-byte blocks, 0x400 data blocks
// - Cacheable load miss allocates and fills block
// - Cancelled speculative fetches stay valid in cache
// - Predicted-taken return fetch loads target block
// - Unconditional branch destination may be prefetched too
// - 64-bit bus fetches doubleword pair together
// - Whole-lock bit locks instruction cache entirely
// - Way-lock value n locks ways 0..n-1
// - Whole lock overrides way-lock field
// - Locked cache: hits served, misses inhibited
// - Invalid entries in way-locked ways remain fillable; whole lock inhibits their fill
`timescale 1ns/1ps
module cache_lock_invalidate_ctrl
  import cache_lock_pkg::*;
#(
  parameter int SETS = cache_lock_pkg::NUM_SETS,
  parameter int WAYS = cache_lock_pkg::NUM_WAYS,
  parameter int BUS_W = cache_lock_pkg::BUS_DATA_W
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_spr_wr,
  input wire logic i_spr_rd,
  input wire logic i_spr_sel,
  input wire logic [31:0] i_spr_wdata,
  output logic [31:0] o_spr_rdata,
  input wire logic i_ifetch_req,
  input wire logic [cache_lock_pkg::ADDR_W-1:0] i_ifetch_addr,
  output logic o_ifetch_hit,
  output logic o_ifetch_fill,
  output logic o_ifetch_inhibit,
  output logic o_ifetch_pair,
  output logic [$clog2(WAYS)-1:0] o_ifetch_way,
  input wire logic i_dload_req,
  input wire logic i_dload_cacheable,
  input wire logic i_dstore_req,
  input wire logic i_dflush_req,
  input wire logic [cache_lock_pkg::ADDR_W-1:0] i_daddr,
  output logic o_dload_hit,
  output logic o_dload_fill,
  output logic o_dload_inhibit,
  output logic o_wb_req,
  output logic [cache_lock_pkg::ADDR_W-1:0] o_wb_addr,
  output logic o_icache_inv_done,
  output logic o_dcache_inv_done
);
  import cache_lock_pkg::*;

  localparam int WAY_W = $clog2(WAYS);
  localparam int SET_W = $clog2(SETS);
  localparam int TAG_W = ADDR_W - SET_W - OFF_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The doubleword pair fetch that preloading depends on needs a 64-bit bus.
  if (BUS_W != 64) begin : g_bad_bus
    $error("cache_lock_invalidate_ctrl: preload needs a 64-bit system data bus");
  end
  // Way-lock field tops out at 7, so at least 8 ways keep one way unlocked.
  if (WAYS < 8 || (1 << WAY_W) != WAYS || (1 << SET_W) != SETS) begin : g_bad_geom
    $error("cache_lock_invalidate_ctrl: ways must be a power of two, at least 8");
  end
  if (SETS * WAYS * BLOCK_BYTES != DATA_BLOCKS * BLOCK_BYTES) begin : g_bad_size
    $error("cache_lock_invalidate_ctrl: data cache must hold 0x400 blocks");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cache_ctrl;
    logic [31:0] way_lock;
    logic [SETS-1:0][WAYS-1:0] i_valid;
    logic [SETS-1:0][WAYS-1:0][TAG_W-1:0] i_tag;
    logic [SETS-1:0][WAYS-1:0] d_valid;
    logic [SETS-1:0][WAYS-1:0] d_dirty;
    logic [SETS-1:0][WAYS-1:0][TAG_W-1:0] d_tag;
    logic [WAY_W-1:0] i_rr;
    logic [WAY_W-1:0] d_rr;
    logic [31:0] rdata;
    logic ihit;
    logic ifill;
    logic iinh;
    logic ipair;
    logic [WAY_W-1:0] iway;
    logic dhit;
    logic dfill;
    logic dinh;
    logic wb_req;
    logic [ADDR_W-1:0] wb_addr;
    logic iinv_done;
    logic dinv_done;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [SET_W-1:0] iset;
  logic [TAG_W-1:0] itag;
  logic [SET_W-1:0] dset;
  logic [TAG_W-1:0] dtag;
  logic [WAYS-1:0] i_hit_vec;
  logic [WAYS-1:0] d_hit_vec;
  logic [WAY_W-1:0] i_hit_way;
  logic [WAY_W-1:0] d_hit_way;
  logic [WAYS-1:0] i_lock_mask;
  logic [IWAY_LOCK_W-1:0] iway_field;
  logic whole_whole_instr_cache_lock;
  logic [WAY_W-1:0] i_vict;
  logic i_vict_ok;
  logic i_vict_valid;
  logic [WAY_W-1:0] d_vict;
  logic d_vict_ok;
  logic d_vict_valid;

  assign iset = i_ifetch_addr[OFF_W +: SET_W];
  assign itag = i_ifetch_addr[ADDR_W-1 -: TAG_W];
  assign dset = i_daddr[OFF_W +: SET_W];
  assign dtag = i_daddr[ADDR_W-1 -: TAG_W];
  assign whole_whole_instr_cache_lock = s_r.cache_ctrl[WHOLE_WHOLE_INSTR_CACHE_LOCK_BIT];
  assign iway_field = s_r.way_lock[IWAY_LOCK_LSB +: IWAY_LOCK_W];

  // ----------------------------------------------------------------
  // Lookup and lock mask
  // ----------------------------------------------------------------
  always_comb begin
    i_hit_way = '0;
    d_hit_way = '0;
    for (int w = 0; w < WAYS; w++) begin
      i_hit_vec[w] = s_r.i_valid[iset][w] && (s_r.i_tag[iset][w] == itag);
      d_hit_vec[w] = s_r.d_valid[dset][w] && (s_r.d_tag[dset][w] == dtag);
      // Thermometer from way 0 upward; whole lock forces every way
      i_lock_mask[w] = whole_whole_instr_cache_lock || (w < int'(iway_field));
      if (i_hit_vec[w]) begin
        i_hit_way = WAY_W'(w);
      end
      if (d_hit_vec[w]) begin
        d_hit_way = WAY_W'(w);
      end
    end
  end

  lock_victim_sel #(.WAYS(WAYS), .WAY_W(WAY_W)) u_ivict (
    .i_valid(s_r.i_valid[iset]),
    .i_locked(i_lock_mask),
    .i_rr_ptr(s_r.i_rr),
    .o_way(i_vict),
    .o_found(i_vict_ok),
    .o_victim_valid(i_vict_valid)
  );

  lock_victim_sel #(.WAYS(WAYS), .WAY_W(WAY_W)) u_dvict (
    .i_valid(s_r.d_valid[dset]),
    .i_locked({WAYS{1'b0}}),
    .i_rr_ptr(s_r.d_rr),
    .o_way(d_vict),
    .o_found(d_vict_ok),
    .o_victim_valid(d_vict_valid)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ihit = 1'b0;
    s_nxt.ifill = 1'b0;
    s_nxt.iinh = 1'b0;
    s_nxt.ipair = 1'b0;
    s_nxt.dhit = 1'b0;
    s_nxt.dfill = 1'b0;
    s_nxt.dinh = 1'b0;
    s_nxt.wb_req = 1'b0;
    s_nxt.iinv_done = 1'b0;
    s_nxt.dinv_done = 1'b0;

    if (i_spr_rd) begin
      s_nxt.rdata = (i_spr_sel == SEL_WAY_LOCK) ? s_r.way_lock : s_r.cache_ctrl;
    end
    if (i_spr_wr) begin
      if (i_spr_sel == SEL_WAY_LOCK) begin
        s_nxt.way_lock = i_spr_wdata;
      end else begin
        s_nxt.cache_ctrl = i_spr_wdata;
      end
    end

    // Speculative and demand fetches take the same path, so a block fetched
    // for a cancelled stream stays valid: nothing here listens to cancels.
    if (i_ifetch_req) begin
      s_nxt.iway = i_hit_way;
      if (|i_hit_vec) begin
        s_nxt.ihit = 1'b1;
      end else if (whole_whole_instr_cache_lock || !i_vict_ok) begin
        s_nxt.iinh = 1'b1;
      end else begin
        // Fills land in invalid entries of locked ways too
        s_nxt.ifill = 1'b1;
        s_nxt.iway = i_vict;
        s_nxt.i_valid[iset][i_vict] = 1'b1;
        s_nxt.i_tag[iset][i_vict] = itag;
        if (i_vict_valid) begin
          s_nxt.i_rr = i_vict + 1'b1;
        end
      end
      // Both words of an aligned doubleword come in one beat of the wide bus
      s_nxt.ipair = !i_ifetch_addr[DWORD_ADDR_BIT] && !(s_nxt.iinh);
    end

    // One data operation per cycle: flush, then store, then load
    if (i_dflush_req) begin
      if (|d_hit_vec) begin
        s_nxt.wb_req = s_r.d_dirty[dset][d_hit_way];
        s_nxt.wb_addr = {dtag, dset, {OFF_W{1'b0}}};
        s_nxt.d_valid[dset][d_hit_way] = 1'b0;
        s_nxt.d_dirty[dset][d_hit_way] = 1'b0;
      end
    end else if (i_dstore_req) begin
      if (|d_hit_vec) begin
        s_nxt.d_dirty[dset][d_hit_way] = 1'b1;
      end
    end else if (i_dload_req) begin
      if (|d_hit_vec) begin
        s_nxt.dhit = 1'b1;
      end else if (!i_dload_cacheable || !d_vict_ok) begin
        s_nxt.dinh = 1'b1;
      end else begin
        // Evicting a modified line pushes it out before the block is reused
        s_nxt.dfill = 1'b1;
        s_nxt.wb_req = d_vict_valid && s_r.d_dirty[dset][d_vict];
        s_nxt.wb_addr = {s_r.d_tag[dset][d_vict], dset, {OFF_W{1'b0}}};
        s_nxt.d_valid[dset][d_vict] = 1'b1;
        s_nxt.d_dirty[dset][d_vict] = 1'b0;
        s_nxt.d_tag[dset][d_vict] = dtag;
        if (d_vict_valid) begin
          s_nxt.d_rr = d_vict + 1'b1;
        end
      end
    end

    // Flash invalidate fires on the clearing write; it wins over a same-cycle
    // fill and never touches the lock fields.
    if (s_r.cache_ctrl[IFLASH_INV_BIT] && !s_nxt.cache_ctrl[IFLASH_INV_BIT]) begin
      s_nxt.i_valid = '0;
      s_nxt.iinv_done = 1'b1;
    end
    if (s_r.cache_ctrl[DFLASH_INV_BIT] && !s_nxt.cache_ctrl[DFLASH_INV_BIT]) begin
      // Modified data is dropped here, no writeback is raised
      s_nxt.d_valid = '0;
      s_nxt.d_dirty = '0;
      s_nxt.wb_req = 1'b0;
      s_nxt.dinv_done = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.cache_ctrl <= CACHE_CTRL_RST;
      s_r.way_lock <= WAY_LOCK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_spr_rdata = s_r.rdata;
  assign o_ifetch_hit = s_r.ihit;
  assign o_ifetch_fill = s_r.ifill;
  assign o_ifetch_inhibit = s_r.iinh;
  assign o_ifetch_pair = s_r.ipair;
  assign o_ifetch_way = s_r.iway;
  assign o_dload_hit = s_r.dhit;
  assign o_dload_fill = s_r.dfill;
  assign o_dload_inhibit = s_r.dinh;
  assign o_wb_req = s_r.wb_req;
  assign o_wb_addr = s_r.wb_addr;
  assign o_icache_inv_done = s_r.iinv_done;
  assign o_dcache_inv_done = s_r.dinv_done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  sequence iflash_pulse_s;
    s_r.cache_ctrl[IFLASH_INV_BIT] ##1 !s_r.cache_ctrl[IFLASH_INV_BIT];
  endsequence
  sequence dflash_pulse_s;
    s_r.cache_ctrl[DFLASH_INV_BIT] ##1 !s_r.cache_ctrl[DFLASH_INV_BIT];
  endsequence

  iflash_clear_a: assert property (iflash_pulse_s |-> s_r.i_valid == '0
      && o_icache_inv_done)
    else $error("instruction flash invalidate left valid blocks");
  dflash_clear_a: assert property (dflash_pulse_s |-> s_r.d_valid == '0 && !o_wb_req)
    else $error("data flash invalidate left blocks or wrote back");
  iflash_keeps_lock_a: assert property (iflash_pulse_s |-> $stable(s_r.way_lock))
    else $error("flash invalidate altered way lock field");
  flush_writeback_a: assert property ((i_dflush_req && (|d_hit_vec)
      && s_r.d_dirty[dset][d_hit_way]) |=> o_wb_req)
    else $error("dirty block flush raised no writeback");
  load_fill_a: assert property ((i_dload_req && !i_dflush_req && !i_dstore_req
      && !(|d_hit_vec) && i_dload_cacheable) |=> o_dload_fill && !o_dload_hit)
    else $error("cacheable load miss did not fill");
  locked_miss_a: assert property ((i_ifetch_req && whole_whole_instr_cache_lock && !(|i_hit_vec))
      |=> o_ifetch_inhibit && !o_ifetch_fill)
    else $error("miss in a fully locked cache was filled");
  locked_stable_a: assert property ((whole_whole_instr_cache_lock && !i_spr_wr) [*2]
      |-> $stable(s_r.i_valid))
    else $error("fully locked instruction cache changed contents");
  victim_unlocked_a: assert property ((i_ifetch_req && !whole_whole_instr_cache_lock && !(|i_hit_vec)
      && i_vict_valid) |-> !i_lock_mask[i_vict])
    else $error("replacement chose a locked way");
  way_lock_map_a: assert property (!whole_whole_instr_cache_lock
      |-> i_lock_mask == ((WAYS'(1) << iway_field) - WAYS'(1)))
    else $error("way lock mask does not match field");
  whole_lock_all_a: assert property (whole_whole_instr_cache_lock |-> &i_lock_mask)
    else $error("whole lock left a way unlocked");
  pair_fetch_a: assert property (o_ifetch_pair |-> o_ifetch_hit || o_ifetch_fill)
    else $error("pair fetch flagged without a cached fetch");

endmodule : cache_lock_invalidate_ctrl

// >>> dv/core_side_model.sv
// Far-side model: fetch unit and load/store unit, one request at a time.
// Assumes the controller takes a request on the edge after it is driven.
`timescale 1ns/1ps
module core_side_model (
  input wire logic i_core_clk,
  output logic o_ifetch_req,
  output logic [31:0] o_ifetch_addr,
  output logic o_dload_req,
  output logic o_dload_cacheable,
  output logic o_dstore_req,
  output logic o_dflush_req,
  output logic [31:0] o_daddr
);
  initial begin
    {o_ifetch_req, o_dload_req, o_dstore_req, o_dflush_req, o_dload_cacheable} = 5'h0;
    o_ifetch_addr = 32'h0;
    o_daddr = 32'h0;
  end

  // Preload loop itself is never fetched: it lives in inhibited space
  task automatic fetch(input logic [31:0] a);
    @(posedge i_core_clk);
    o_ifetch_req <= 1'b1;
    o_ifetch_addr <= a;
    @(posedge i_core_clk);
    o_ifetch_req <= 1'b0;
    // Released address shows garbage, not the last value
    o_ifetch_addr <= ~a;
  endtask : fetch

  // Kind 0 load, 1 store, 2 flush; only guarded-safe memory is touched
  task automatic data(input logic [1:0] k, input logic [31:0] a, input logic c);
    @(posedge i_core_clk);
    o_dload_req <= (k == 2'h0);
    o_dstore_req <= (k == 2'h1);
    o_dflush_req <= (k == 2'h2);
    o_dload_cacheable <= c;
    o_daddr <= a;
    @(posedge i_core_clk);
    {o_dload_req, o_dstore_req, o_dflush_req} <= 3'h0;
    o_dload_cacheable <= ~c;
    o_daddr <= ~a;
  endtask : data
endmodule : core_side_model

// >>> dv/tb.sv
// Self-checking bench for the cache lock and invalidate controller.
// Assumes core_side_model drives requests and answers come one edge later.
`timescale 1ns/1ps
module tb;
  import cache_lock_pkg::*;
  logic i_core_clk, i_rstn, i_spr_wr, i_spr_rd, i_spr_sel;
  logic [31:0] i_spr_wdata, o_spr_rdata, i_ifetch_addr, i_daddr, o_wb_addr, r;
  logic i_ifetch_req, i_dload_req, i_dload_cacheable, i_dstore_req, i_dflush_req;
  logic o_ifetch_hit, o_ifetch_fill, o_ifetch_inhibit, o_ifetch_pair, o_dload_hit;
  logic o_dload_fill, o_dload_inhibit, o_wb_req, o_icache_inv_done, o_dcache_inv_done;
  logic [2:0] o_ifetch_way;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 32'h0e069fdc;

  cache_lock_invalidate_ctrl u_dut (.i_core_clk, .i_rstn, .i_spr_wr, .i_spr_rd, .i_spr_sel,
    .i_spr_wdata, .o_spr_rdata, .i_ifetch_req, .i_ifetch_addr, .o_ifetch_hit, .o_ifetch_fill,
    .o_ifetch_inhibit, .o_ifetch_pair, .o_ifetch_way, .i_dload_req, .i_dload_cacheable,
    .i_dstore_req, .i_dflush_req, .i_daddr, .o_dload_hit, .o_dload_fill, .o_dload_inhibit,
    .o_wb_req, .o_wb_addr, .o_icache_inv_done, .o_dcache_inv_done);
  core_side_model core (.i_core_clk, .o_ifetch_req(i_ifetch_req),
    .o_ifetch_addr(i_ifetch_addr), .o_dload_req(i_dload_req),
    .o_dload_cacheable(i_dload_cacheable), .o_dstore_req(i_dstore_req),
    .o_dflush_req(i_dflush_req), .o_daddr(i_daddr));

  // ----------------------------------------------------------------
  // Checking and register tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic s, input logic [31:0] d);
    @(posedge i_core_clk);
    i_spr_wr <= 1'b1;
    i_spr_sel <= s;
    i_spr_wdata <= d;
    @(posedge i_core_clk);
    i_spr_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic s, input logic [31:0] e);
    @(posedge i_core_clk);
    i_spr_rd <= 1'b1;
    i_spr_sel <= s;
    @(posedge i_core_clk);
    i_spr_rd <= 1'b0;
    #1;
    chk(o_spr_rdata, e);
  endtask : rdchk

  // Two words share a beat only from an aligned doubleword that is cached
  function automatic logic exp_pair(input logic [31:0] a, input logic inh);
    return ~a[2] & ~inh;
  endfunction : exp_pair

  // Set then clear a flash bit; the done pulse must show within four edges
  task automatic flash(input logic [31:0] base, input logic d);
    int j;
    logic seen;
    seen = 1'b0;
    wr(SEL_CACHE_CTRL, base | (d ? DFLASH_INV_MASK : IFLASH_INV_MASK));
    wr(SEL_CACHE_CTRL, base);
    for (j = 0; j < 4; j++) begin
      #1 seen |= d ? o_dcache_inv_done : o_icache_inv_done;
      @(posedge i_core_clk);
    end
    chk(seen, 1'b1);
  endtask : flash

  // Way 4'hf means the way is not compared
  task automatic ifetch(input logic [31:0] a, input logic [2:0] e, input logic [3:0] w);
    core.fetch(a);
    #1;
    chk({o_ifetch_hit, o_ifetch_fill, o_ifetch_inhibit}, e);
    chk(o_ifetch_pair, exp_pair(a, e[0]));
    if (w != 4'hf) chk(o_ifetch_way, w);
  endtask : ifetch

  task automatic dchk(input logic [1:0] k, input logic [31:0] a, input logic c,
                      input logic [3:0] e);
    core.data(k, a, c);
    #1;
    chk({o_dload_hit, o_dload_fill, o_dload_inhibit, o_wb_req}, e);
  endtask : dchk

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  initial begin
    #500000;
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i, n;
    logic [31:0] a;
    i_rstn = 1'b0;
    {i_spr_wr, i_spr_rd, i_spr_sel} = 3'h0;
    i_spr_wdata = 32'h0;
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    rdchk(SEL_CACHE_CTRL, CACHE_CTRL_RST);
    rdchk(SEL_WAY_LOCK, WAY_LOCK_RST);
    r = $random(seed);
    wr(SEL_WAY_LOCK, r);
    rdchk(SEL_WAY_LOCK, r);
    r = $random(seed);
    wr(SEL_CACHE_CTRL, r);
    rdchk(SEL_CACHE_CTRL, r);
    wr(SEL_WAY_LOCK, 32'h0);
    wr(SEL_CACHE_CTRL, 32'h0);
    flash(32'h0, 1'b1);
    // Whole data cache fills block by block, then every block hits
    for (i = 0; i < DATA_BLOCKS; i++)
      dchk(2'h0, 32'(i * BLOCK_BYTES), 1'b1, 4'b0100);
    for (i = 0; i < DATA_BLOCKS; i++)
      dchk(2'h0, 32'(i * BLOCK_BYTES + ($random(seed) & 31)), 1'b1, 4'b1000);
    a = 32'h40 + ($random(seed) & 31);
    dchk(2'h1, a, 1'b1, 4'b0000);
    dchk(2'h1, 32'h10000, 1'b1, 4'b0000);
    dchk(2'h2, a ^ 32'h1c, 1'b1, 4'b0001);
    chk(o_wb_addr, 32'h40);
    dchk(2'h2, 32'h40, 1'b1, 4'b0000);
    dchk(2'h0, 32'h44, 1'b0, 4'b0010);
    dchk(2'h0, 32'h40, 1'b1, 4'b0100);
    dchk(2'h1, 32'h60, 1'b1, 4'b0000);
    flash(32'h0, 1'b1);
    dchk(2'h0, 32'h60, 1'b1, 4'b0100);
    // Instruction side: random fetches fill, neighbouring word then hits
    flash(32'h0, 1'b0);
    for (i = 0; i < 8; i++) begin
      a = $random(seed);
      ifetch(a, 3'b010, 4'hf);
      ifetch(a ^ 32'h4, 3'b100, 4'hf);
    end
    for (n = 1; n < 8; n++) begin
      wr(SEL_WAY_LOCK, 32'(n) << IWAY_LOCK_LSB);
      flash(32'h0, 1'b0);
      rdchk(SEL_WAY_LOCK, 32'(n) << IWAY_LOCK_LSB);
      for (i = 0; i < 8; i++) ifetch(32'h1000 * i + 32'h20, 3'b010, 4'(i));
      ifetch(32'h8020, 3'b010, 4'hf);
      chk(o_ifetch_way >= n, 1'b1);
      for (i = 0; i < n; i++) ifetch(32'h1000 * i + 32'h20, 3'b100, 4'(i));
    end
    flash(32'h0, 1'b0);
    ifetch(32'h100, 3'b010, 4'h0);
    wr(SEL_CACHE_CTRL, WHOLE_WHOLE_INSTR_CACHE_LOCK_MASK);
    ifetch(32'h100, 3'b100, 4'h0);
    ifetch(32'h3100, 3'b001, 4'hf);
    ifetch(32'h3100, 3'b001, 4'hf);
    flash(WHOLE_WHOLE_INSTR_CACHE_LOCK_MASK, 1'b0);
    rdchk(SEL_CACHE_CTRL, WHOLE_WHOLE_INSTR_CACHE_LOCK_MASK);
    ifetch(32'h100, 3'b001, 4'hf);
    wr(SEL_CACHE_CTRL, 32'h0);
    ifetch(32'h100, 3'b010, 4'h0);
    complete_run();
  end
endmodule : tb
